// ### alpd_top.sv
// level and pulse motion/freefall detector with host registers
// What this block does
// - option bit clear compares magnitudes, sign ignored
// - set disable bit excludes that axis
// - x disable sits at bit 3
// - level combine set: all enabled axes below
// - level combine clear: any enabled axis above
// - level threshold is sixteenth g per count
// - pulse OR mode detects single or double pulse
// - pulse counts only if shorter than pulse width
// - pulse AND: below longer than latency flags
// - level detection has no timer qualification
// - threshold comparison at sixteen counts per g
// - latency counts one millisecond per count
module alpd_top #(
    parameter int unsigned HALF_MS_CYCLES = alpd_pkg::HALF_MS_CYCLES
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // host register port
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    // acceleration samples, 16 counts per g
    input  wire logic [7:0] sampleX,
    input  wire logic [7:0] sampleY,
    input  wire logic [7:0] sampleZ,
    input  wire logic       sampleValid,
    // sticky event flags
    output logic            levelEvent,
    output logic            pulseEvent
);
    localparam int DIV_W = $clog2(HALF_MS_CYCLES);

    if (HALF_MS_CYCLES < 2) begin : g_check
        $error("HALF_MS_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [7:0]           cfg1;
        logic [7:0]           cfg2;
        logic [7:0]           lvlTh;
        logic [7:0]           pulseTh;
        logic [7:0]           pulseWidth;
        logic [7:0]           latency;
        logic [7:0]           window;
        logic [7:0]           flags;
        logic [7:0]           dbl;
        logic [7:0]           rdData;
        logic                 rdValid;
        alpd_pkg::alpd_pulse_e pstate;
        logic [8:0]           timer;
        logic [2:0]           pulseAxes;
        logic [DIV_W-1:0]     divCnt;
        logic                 halfTick;
        logic                 msPhase;
    } alpd_state_s;

    alpd_state_s state_reg;
    alpd_state_s state_next;

    alpd_cmp_if lvlCmp ();
    alpd_cmp_if pulseCmp ();

    logic [2:0] axisEn;
    logic       msTick;

    // cleared disable bit enables the axis
    assign axisEn = ~{state_reg.cfg1[alpd_pkg::CFG1_Z_DIS],
                      state_reg.cfg1[alpd_pkg::CFG1_Y_DIS],
                      state_reg.cfg1[alpd_pkg::CFG1_X_DIS]};
    // millisecond tick is every second half tick
    assign msTick = state_reg.halfTick & state_reg.msPhase;

    // raw counts compared, scale fixed by sample format
    assign lvlCmp.sample      = {sampleZ, sampleY, sampleX};
    assign lvlCmp.threshold   = state_reg.lvlTh;
    // absolute when the option bit is clear
    assign lvlCmp.absMode     = ~state_reg.cfg1[alpd_pkg::CFG1_SIGN_OPT];
    assign lvlCmp.axisEn      = axisEn;
    assign pulseCmp.sample    = {sampleZ, sampleY, sampleX};
    assign pulseCmp.threshold = state_reg.pulseTh;
    assign pulseCmp.absMode   = ~state_reg.cfg1[alpd_pkg::CFG1_SIGN_OPT];
    assign pulseCmp.axisEn    = axisEn;

    alpd_compare u_lvlCmp (
        .port (lvlCmp.cmp)
    );
    alpd_compare u_pulseCmp (
        .port (pulseCmp.cmp)
    );

    always_comb begin
        logic       lvlAnd;
        logic       pAnd;
        logic       pAbove;
        logic       pAllBelow;
        logic       timed;
        lvlAnd    = state_reg.cfg2[alpd_pkg::CFG2_LEVEL_COMBINE];
        pAnd      = state_reg.cfg2[alpd_pkg::CFG2_PULSE_COMBINE];
        pAbove    = |pulseCmp.above;
        // no enabled axis must not read as freefall
        pAllBelow = (pulseCmp.below == axisEn) && (|axisEn);
        timed     = 1'b0;
        state_next = state_reg;
        state_next.rdValid = 1'b0;

        // half millisecond divider
        if (state_reg.divCnt == DIV_W'(HALF_MS_CYCLES - 1)) begin
            state_next.divCnt   = '0;
            state_next.halfTick = 1'b1;
        end else begin
            state_next.divCnt   = state_reg.divCnt + 1'b1;
            state_next.halfTick = 1'b0;
        end
        if (state_reg.halfTick) begin
            state_next.msPhase = ~state_reg.msPhase;
        end

        if (regRdEn) begin
            state_next.rdValid = 1'b1;
            unique case (regAddr)
                alpd_pkg::ADDR_FLAGS:       state_next.rdData = state_reg.flags;
                alpd_pkg::ADDR_DOUBLE:      state_next.rdData = state_reg.dbl;
                alpd_pkg::ADDR_CFG1:        state_next.rdData = state_reg.cfg1;
                alpd_pkg::ADDR_CFG2:        state_next.rdData = state_reg.cfg2;
                alpd_pkg::ADDR_LVL_TH:      state_next.rdData = state_reg.lvlTh;
                alpd_pkg::ADDR_PULSE_TH:    state_next.rdData = state_reg.pulseTh;
                alpd_pkg::ADDR_PULSE_WIDTH: state_next.rdData = state_reg.pulseWidth;
                alpd_pkg::ADDR_LATENCY:     state_next.rdData = state_reg.latency;
                alpd_pkg::ADDR_WINDOW:      state_next.rdData = state_reg.window;
                default:                    state_next.rdData = alpd_pkg::RESET_VALUE;
            endcase
        end

        if (regWrEn) begin
            unique case (regAddr)
                alpd_pkg::ADDR_FLAGS:
                    state_next.flags = state_reg.flags & ~regWrData;
                alpd_pkg::ADDR_DOUBLE:
                    state_next.dbl = state_reg.dbl & ~regWrData;
                // x disable lands at bit 3 with the byte
                alpd_pkg::ADDR_CFG1:        state_next.cfg1 = regWrData;
                alpd_pkg::ADDR_CFG2:
                    state_next.cfg2 = regWrData & alpd_pkg::CFG2_MASK;
                // threshold kept as raw sixteenth g counts
                alpd_pkg::ADDR_LVL_TH:      state_next.lvlTh = regWrData;
                alpd_pkg::ADDR_PULSE_TH:    state_next.pulseTh = regWrData;
                alpd_pkg::ADDR_PULSE_WIDTH: state_next.pulseWidth = regWrData;
                alpd_pkg::ADDR_LATENCY:     state_next.latency = regWrData;
                alpd_pkg::ADDR_WINDOW:      state_next.window = regWrData;
                default: ;
            endcase
        end

        // level result from this sample only
        if (sampleValid) begin
            if (lvlAnd) begin
                // freefall needs every enabled axis below
                if ((lvlCmp.below == axisEn) && (|axisEn)) begin
                    state_next.flags[alpd_pkg::FLAG_LEVEL_EVENT] = 1'b1;
                    state_next.flags[alpd_pkg::FLAG_LEVEL_AXES +: 3] =
                        state_next.flags[alpd_pkg::FLAG_LEVEL_AXES +: 3]
                        | lvlCmp.below;
                end
            end else if (|lvlCmp.above) begin
                // any enabled axis above is motion
                state_next.flags[alpd_pkg::FLAG_LEVEL_EVENT] = 1'b1;
                state_next.flags[alpd_pkg::FLAG_LEVEL_AXES +: 3] =
                    state_next.flags[alpd_pkg::FLAG_LEVEL_AXES +: 3]
                    | lvlCmp.above;
            end
        end

        // pulse widths run on half ms, other phases on whole ms
        if (!pAnd && (state_reg.pstate == alpd_pkg::PS_FIRST ||
                      state_reg.pstate == alpd_pkg::PS_SECOND)) begin
            timed = state_reg.halfTick;
        end else begin
            timed = msTick;
        end
        if (timed && state_reg.timer != 9'h1ff) begin
            state_next.timer = state_reg.timer + 1'b1;
        end

        unique case (state_reg.pstate)
            alpd_pkg::PS_IDLE: begin
                state_next.timer = '0;
                // OR selection looks for pulses above
                if (sampleValid && (pAnd ? pAllBelow : pAbove)) begin
                    state_next.pstate    = alpd_pkg::PS_FIRST;
                    state_next.pulseAxes = pAnd ? axisEn : pulseCmp.above;
                end
            end
            alpd_pkg::PS_FIRST: begin
                if (pAnd) begin
                    if (sampleValid && !pAllBelow) begin
                        state_next.pstate = alpd_pkg::PS_IDLE;
                    end else if (state_reg.timer > {1'b0, state_reg.latency}) begin
                        state_next.flags[alpd_pkg::FLAG_PULSE_EVENT] = 1'b1;
                        state_next.flags[alpd_pkg::FLAG_PULSE_AXES +: 3] =
                            state_next.flags[alpd_pkg::FLAG_PULSE_AXES +: 3]
                            | state_reg.pulseAxes;
                        state_next.pstate = alpd_pkg::PS_HOLD;
                    end
                // held too long is no pulse
                end else if (state_reg.timer > {1'b0, state_reg.pulseWidth}) begin
                    state_next.pstate = alpd_pkg::PS_HOLD;
                end else if (sampleValid && !pAbove) begin
                    state_next.flags[alpd_pkg::FLAG_PULSE_EVENT] = 1'b1;
                    state_next.flags[alpd_pkg::FLAG_PULSE_AXES +: 3] =
                        state_next.flags[alpd_pkg::FLAG_PULSE_AXES +: 3]
                        | state_reg.pulseAxes;
                    state_next.timer  = '0;
                    state_next.pstate = alpd_pkg::PS_LATENCY;
                end else if (sampleValid) begin
                    state_next.pulseAxes = state_reg.pulseAxes | pulseCmp.above;
                end
            end
            alpd_pkg::PS_LATENCY: begin
                if (state_reg.timer >= {1'b0, state_reg.latency}) begin
                    state_next.timer  = '0;
                    state_next.pstate = alpd_pkg::PS_WINDOW;
                end
            end
            alpd_pkg::PS_WINDOW: begin
                if (state_reg.timer >= {1'b0, state_reg.window}) begin
                    state_next.pstate = alpd_pkg::PS_IDLE;
                end else if (sampleValid && pAbove) begin
                    state_next.timer  = '0;
                    state_next.pstate = alpd_pkg::PS_SECOND;
                end
            end
            alpd_pkg::PS_SECOND: begin
                // second pulse also bounded by width
                if (state_reg.timer > {1'b0, state_reg.pulseWidth}) begin
                    state_next.pstate = alpd_pkg::PS_HOLD;
                end else if (sampleValid && !pAbove) begin
                    state_next.flags[alpd_pkg::FLAG_PULSE_EVENT] = 1'b1;
                    state_next.dbl[alpd_pkg::DOUBLE_BIT] = 1'b1;
                    state_next.pstate = alpd_pkg::PS_IDLE;
                end
            end
            alpd_pkg::PS_HOLD: begin
                // wait for the condition to end, avoids retriggering
                if (sampleValid && (pAnd ? !pAllBelow : !pAbove)) begin
                    state_next.pstate = alpd_pkg::PS_IDLE;
                end
            end
            default: state_next.pstate = alpd_pkg::PS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdData  = state_reg.rdData;
    assign regRdValid = state_reg.rdValid;
    assign levelEvent = state_reg.flags[alpd_pkg::FLAG_LEVEL_EVENT];
    assign pulseEvent = state_reg.flags[alpd_pkg::FLAG_PULSE_EVENT];
endmodule

// ### alpd_pkg.sv
// shared constants and types of the level and pulse detector
package alpd_pkg;
    // register offsets on the host register port
    localparam logic [7:0] ADDR_FLAGS       = 8'h0a;
    localparam logic [7:0] ADDR_DOUBLE      = 8'h0c;
    localparam logic [7:0] ADDR_CFG1        = 8'h18;
    localparam logic [7:0] ADDR_CFG2        = 8'h19;
    localparam logic [7:0] ADDR_LVL_TH      = 8'h1a;
    localparam logic [7:0] ADDR_PULSE_TH    = 8'h1b;
    localparam logic [7:0] ADDR_PULSE_WIDTH = 8'h1c;
    localparam logic [7:0] ADDR_LATENCY     = 8'h1d;
    localparam logic [7:0] ADDR_WINDOW      = 8'h1e;

    // control_register_one fields
    localparam int CFG1_SIGN_OPT = 6;
    localparam int CFG1_Z_DIS    = 5;
    localparam int CFG1_Y_DIS    = 4;
    localparam int CFG1_X_DIS    = 3;
    // control_register_two fields
    localparam int         CFG2_LEVEL_COMBINE = 0;
    localparam int         CFG2_PULSE_COMBINE = 1;
    localparam logic [7:0] CFG2_MASK          = 8'h07;

    // flag register fields, axis index 0 is x
    localparam int FLAG_LEVEL_EVENT = 0;
    localparam int FLAG_PULSE_EVENT = 1;
    localparam int FLAG_PULSE_AXES  = 2;
    localparam int FLAG_LEVEL_AXES  = 5;
    localparam int DOUBLE_BIT       = 0;

    localparam logic [7:0] RESET_VALUE = 8'h00;

    // timing: half millisecond base tick
    localparam int CLOCK_MHZ      = 25;
    localparam int HALF_MS_US     = 500;
    localparam int HALF_MS_CYCLES = CLOCK_MHZ * HALF_MS_US;

    typedef enum logic [2:0] {
        PS_IDLE,
        PS_FIRST,
        PS_LATENCY,
        PS_WINDOW,
        PS_SECOND,
        PS_HOLD
    } alpd_pulse_e;
endpackage

// ### alpd_cmp_if.sv
// carrier between the detector and one threshold comparator
interface alpd_cmp_if;
    logic [2:0][7:0] sample;
    logic [7:0]      threshold;
    logic            absMode;
    logic [2:0]      axisEn;
    logic [2:0]      above;
    logic [2:0]      below;

    modport user (
        output sample,
        output threshold,
        output absMode,
        output axisEn,
        input  above,
        input  below
    );
    modport cmp (
        input  sample,
        input  threshold,
        input  absMode,
        input  axisEn,
        output above,
        output below
    );
endinterface

// ### alpd_compare.sv
// per-axis threshold comparator, absolute or signed
module alpd_compare (
    // comparison request and result
    alpd_cmp_if.cmp port
);
    // nine bits so that the magnitude of -128 still fits
    function automatic logic signed [8:0] operand(
        input logic [7:0] v,
        input logic       absMode
    );
        logic signed [8:0] s;
        s = {v[7], v};
        if (absMode && s < 0) begin
            s = -s;
        end
        return s;
    endfunction

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            port.above[i] = port.axisEn[i] &&
                (operand(port.sample[i], port.absMode) >
                 operand(port.threshold, port.absMode));
            port.below[i] = port.axisEn[i] &&
                (operand(port.sample[i], port.absMode) <
                 operand(port.threshold, port.absMode));
        end
    end
endmodule

// ### alpd_checker.sv
// port assertions of the level and pulse detector
module alpd_checker #(
    parameter int unsigned HALF_MS_CYCLES = 4
) (
    // clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // host register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    // samples and flags
    input wire logic [7:0] sampleX,
    input wire logic [7:0] sampleY,
    input wire logic [7:0] sampleZ,
    input wire logic       sampleValid,
    input wire logic       levelEvent,
    input wire logic       pulseEvent
);
    logic [7:0]      cfg1Reg;
    logic [7:0]      cfg2Reg;
    logic [7:0]      thrReg;
    logic [2:0][7:0] sv;
    logic [2:0]      en;
    logic [2:0]      hiVec;
    logic [2:0]      loVec;
    logic            orHit;
    logic            andHit;
    logic            clrFlag;

    // shadow copies, written on the same edge the design takes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg1Reg <= 8'h00;
            cfg2Reg <= 8'h00;
            thrReg  <= 8'h00;
        end else if (regWrEn) begin
            if (regAddr == 8'h18) cfg1Reg <= regWrData;
            if (regAddr == 8'h19) cfg2Reg <= regWrData;
            if (regAddr == 8'h1a) thrReg <= regWrData;
        end
    end

    function automatic logic [1:0] cmp(logic [7:0] s, logic [7:0] t,
                                       logic sg);
        logic signed [9:0] a;
        logic signed [9:0] b;
        a = $signed({{2{s[7]}}, s});
        b = $signed({{2{t[7]}}, t});
        if (!sg && a < 0) a = -a;
        if (!sg && b < 0) b = -b;
        return {a > b, a < b};
    endfunction

    assign sv = {sampleZ, sampleY, sampleX};
    assign en = ~cfg1Reg[5:3];
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            {hiVec[i], loVec[i]} = cmp(sv[i], thrReg, cfg1Reg[6]);
        end
    end
    assign orHit   = (|(hiVec & en)) && !cfg2Reg[0];
    assign andHit  = (en != 3'b000) && ((loVec | ~en) == 3'b111)
                     && cfg2Reg[0];
    assign clrFlag = regWrEn && (regAddr == 8'h0a);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_rd_ans;
        regRdEn |=> regRdValid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read strobe got no answer");
    property p_rd_cause;
        regRdValid |-> $past(regRdEn);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read answer without a read");
    // writes are spaced by one idle cycle on this port
    property p_cfg1_back;
        regWrEn && regAddr == 8'h18 ##1 !regWrEn
            ##1 regRdEn && regAddr == 8'h18
            |=> regRdData == $past(regWrData, 3);
    endproperty
    a_cfg1_back: assert property (p_cfg1_back)
        else $error("control one readback differs");
    property p_lvl_or;
        sampleValid && orHit |=> levelEvent;
    endproperty
    a_lvl_or: assert property (p_lvl_or)
        else $error("or level hit not flagged");
    property p_lvl_and;
        sampleValid && andHit |=> levelEvent;
    endproperty
    a_lvl_and: assert property (p_lvl_and)
        else $error("and level hit not flagged");
    property p_lvl_quiet;
        !levelEvent && !(sampleValid && (orHit || andHit)) |=> !levelEvent;
    endproperty
    a_lvl_quiet: assert property (p_lvl_quiet)
        else $error("level flag without a hit");
    property p_lvl_hold;
        levelEvent && !(clrFlag && regWrData[0]) |=> levelEvent;
    endproperty
    a_lvl_hold: assert property (p_lvl_hold)
        else $error("level flag lost without clear");
    property p_pls_hold;
        pulseEvent && !(clrFlag && regWrData[1]) |=> pulseEvent;
    endproperty
    a_pls_hold: assert property (p_pls_hold)
        else $error("pulse flag lost without clear");

    c_or: cover property (sampleValid && orHit);
    c_and: cover property (sampleValid && andHit);
    c_pulse: cover property ($rose(pulseEvent));
endmodule

bind alpd_top alpd_checker #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) alpd_chk_inst (
    .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .sampleX(sampleX), .sampleY(sampleY),
    .sampleZ(sampleZ), .sampleValid(sampleValid),
    .levelEvent(levelEvent), .pulseEvent(pulseEvent));

// ### alpd_host_model.sv
// host controller model driving the register port
module alpd_host_model (
    // clock
    input  wire logic       clock,
    // register port
    output logic      [7:0] regAddr,
    output logic            regWrEn,
    output logic      [7:0] regWrData,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regAddr   = 8'h00;
        regWrEn   = 1'b0;
        regWrData = 8'h00;
        regRdEn   = 1'b0;
    end
    // data goes stale after the strobe, so never leave it valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge clock);
        regWrEn   = 1'b0;
        regWrData = ~d;
        @(negedge clock);
    endtask
    // answer stands one cycle only, so take it before lowering
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clock);
        d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
        regRdEn = 1'b0;
        @(negedge clock);
    endtask
endmodule

// ### tb_accel_level_pulse_detect.sv
// self-checking bench of the level and pulse detector
module tb_accel_level_pulse_detect;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] regAddr;
    logic       regWrEn;
    logic [7:0] regWrData;
    logic       regRdEn;
    logic [7:0] regRdData;
    logic       regRdValid;
    logic [7:0] sampleX = 8'h00;
    logic [7:0] sampleY = 8'h00;
    logic [7:0] sampleZ = 8'h00;
    logic       sampleValid = 1'b0;
    logic       levelEvent;
    logic       pulseEvent;
    int         badCount = 0;
    int         totalChecks = 0;

    always #20 clock = ~clock;

    alpd_top #(.HALF_MS_CYCLES(4)) alpd_top_inst (
        .clock(clock), .rstn(rstn), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
        .sampleValid(sampleValid), .levelEvent(levelEvent),
        .pulseEvent(pulseEvent));
    alpd_host_model alpd_host_model_inst (
        .clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid));

    task automatic stopTest();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
        totalChecks++;
        if (g !== e) begin
            badCount++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        alpd_host_model_inst.wr(a, d);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e, string m);
        logic [7:0] d;
        alpd_host_model_inst.rd(a, d);
        chk(d, e, m);
    endtask
    task automatic smp(input logic [7:0] x, input logic [7:0] y,
                       input logic [7:0] z);
        sampleX = x;
        sampleY = y;
        sampleZ = z;
        sampleValid = 1'b1;
        @(negedge clock);
        sampleValid = 1'b0;
        @(negedge clock);
    endtask

    task automatic tRegs();
        rdChk(alpd_pkg::ADDR_CFG1, 8'h00, "cfg1 reset");
        rdChk(alpd_pkg::ADDR_CFG2, 8'h00, "cfg2 reset");
        rdChk(alpd_pkg::ADDR_LVL_TH, 8'h00, "threshold reset");
        rdChk(8'h05, 8'h00, "unmapped read");
        wr(alpd_pkg::ADDR_CFG1, 8'h78);
        rdChk(alpd_pkg::ADDR_CFG1, 8'h78, "cfg1 back");
        wr(alpd_pkg::ADDR_CFG1, 8'h78 ^ 8'h08);
        rdChk(alpd_pkg::ADDR_CFG1, 8'h70, "x toggle");
        wr(alpd_pkg::ADDR_CFG2, 8'hff);
        rdChk(alpd_pkg::ADDR_CFG2, 8'h07, "cfg2 mask");
        wr(alpd_pkg::ADDR_CFG2, 8'h00);
        wr(alpd_pkg::ADDR_PULSE_TH, 8'h7f);
    endtask
    task automatic tLvlOr();
        wr(alpd_pkg::ADDR_CFG1, 8'h20);
        wr(alpd_pkg::ADDR_LVL_TH, 8'h20);
        smp(8'h00, 8'h00, 8'h7f);
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h00, "z disabled");
        smp(8'hdf, 8'h00, 8'h00);
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h21, "abs or hit");
        wr(alpd_pkg::ADDR_FLAGS, 8'hff);
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h00, "flag clear");
        wr(alpd_pkg::ADDR_CFG1, 8'h60);
        smp(8'hdf, 8'h00, 8'h00);
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h00, "signed miss");
        wr(alpd_pkg::ADDR_CFG1, 8'h28);
        smp(8'h21, 8'h00, 8'h00);
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h00, "x disabled");
    endtask
    task automatic tLvlAnd();
        wr(alpd_pkg::ADDR_CFG1, 8'h00);
        wr(alpd_pkg::ADDR_CFG2, 8'h01);
        wr(alpd_pkg::ADDR_LVL_TH, 8'h03);
        smp(8'h02, 8'hfe, 8'h03);
        chk({7'h00, levelEvent}, 8'h00, "and z equal");
        smp(8'h02, 8'hfe, 8'hfd);
        chk({7'h00, levelEvent}, 8'h00, "and z magnitude");
        smp(8'h02, 8'hfe, 8'hfe);
        chk({7'h00, levelEvent}, 8'h01, "and all below");
        smp(8'h10, 8'h10, 8'h10);
        chk({7'h00, levelEvent}, 8'h01, "sticky");
        wr(alpd_pkg::ADDR_CFG2, 8'h00);
        wr(alpd_pkg::ADDR_LVL_TH, 8'h7f);
        wr(alpd_pkg::ADDR_FLAGS, 8'hff);
    endtask
    task automatic tPulseOr();
        int n;
        wr(alpd_pkg::ADDR_CFG2, 8'h00);
        wr(alpd_pkg::ADDR_PULSE_TH, 8'h40);
        wr(alpd_pkg::ADDR_PULSE_WIDTH, 8'h04);
        smp(8'h50, 8'h00, 8'h00);
        repeat (2) @(negedge clock);
        smp(8'h00, 8'h00, 8'h00);
        n = 0;
        while (pulseEvent !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h06, "short pulse");
        wr(alpd_pkg::ADDR_FLAGS, 8'hff);
        smp(8'h50, 8'h00, 8'h00);
        repeat (60) @(negedge clock);
        smp(8'h00, 8'h00, 8'h00);
        repeat (40) @(negedge clock);
        chk({7'h00, pulseEvent}, 8'h00, "long pulse");
    endtask
    // z only pulse, then a second one inside the window
    task automatic tDouble();
        wr(alpd_pkg::ADDR_LATENCY, 8'h01);
        wr(alpd_pkg::ADDR_WINDOW, 8'h08);
        smp(8'h00, 8'h00, 8'h50);
        smp(8'h00, 8'h00, 8'h00);
        repeat (24) @(negedge clock);
        smp(8'h00, 8'h00, 8'h50);
        smp(8'h00, 8'h00, 8'h00);
        rdChk(alpd_pkg::ADDR_DOUBLE, 8'h01, "double pulse");
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h12, "double flags");
        wr(alpd_pkg::ADDR_DOUBLE, 8'hff);
        rdChk(alpd_pkg::ADDR_DOUBLE, 8'h00, "double clear");
        wr(alpd_pkg::ADDR_FLAGS, 8'hff);
    endtask
    task automatic tPulseAnd();
        int n;
        wr(alpd_pkg::ADDR_CFG2, 8'h02);
        wr(alpd_pkg::ADDR_LATENCY, 8'h02);
        smp(8'h50, 8'h00, 8'h00);
        wr(alpd_pkg::ADDR_FLAGS, 8'hff);
        // a fresh quiet sample on every cycle
        sampleX = 8'h00;
        sampleY = 8'h00;
        sampleZ = 8'h00;
        sampleValid = 1'b1;
        n = 0;
        while (pulseEvent !== 1'b1 && n < 80) begin
            @(negedge clock);
            n++;
        end
        sampleValid = 1'b0;
        chk({7'h00, n >= 14 && n <= 40}, 8'h01, "freefall time");
        rdChk(alpd_pkg::ADDR_FLAGS, 8'h1e, "freefall flags");
    endtask

    initial begin
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        tRegs();
        tLvlOr();
        tLvlAnd();
        tPulseOr();
        tDouble();
        tPulseAnd();
        stopTest();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clock);
        badCount++;
        $display("CHECK FAILED %0t run timed out", $time);
        stopTest();
    end
endmodule
